// *** bench/ees_master.sv ***
`timescale 1ns/1ps
// ==========================================
// Bus master model: makes the serial clock and pulls the data line low.
module ees_master (
    input wire logic i_ref_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic q(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // Data moves only while the clock is low; the line is sampled late in the high phase.
    task automatic bit_io(input logic b, output logic s);
        q(2);
        o_sda_oe <= ~b;
        q(2);
        o_scl <= 1'b1;
        q(4);
        s = i_sda;
        o_scl <= 1'b0;
    endtask
    task automatic start();
        o_sda_oe <= 1'b0;
        // The slave may still hold its acknowledge; let it release before the clock rises.
        q(6);
        o_scl <= 1'b1;
        q(4);
        o_sda_oe <= 1'b1;
        q(4);
        o_scl <= 1'b0;
    endtask
    task automatic stop();
        q(2);
        o_sda_oe <= 1'b1;
        q(2);
        o_scl <= 1'b1;
        q(4);
        o_sda_oe <= 1'b0;
        q(4);
    endtask
    task automatic wbyte(input ees_pkg::ees_byte_t d, output logic nak);
        for (int i = 7; i >= 0; i--) bit_io(d[i], nak);
        bit_io(1'b1, nak);
    endtask
    task automatic rbyte(input logic nak, output ees_pkg::ees_byte_t d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nak, s);
    endtask
endmodule // ees_master

// *** bench/ees_slave_bench.sv ***
`timescale 1ns/1ps
`include "ees_defs.svh"
// ==========================================
// Self-checking bench for the serial slave.
module ees_slave_bench;
    localparam int unsigned WCYC = 300;
    logic clk;
    logic rst_b;
    logic addr_sel;
    logic scl;
    logic m_oe;
    logic sda;
    logic o_sda;
    logic o_sda_oe;
    logic busy;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] own;
    logic [7:0] base;
    logic [7:0] newa;
    logic nak;
    ees_pkg::ees_byte_t d;
    ees_pkg::ees_byte_t dq[$];
    ees_pkg::ees_byte_t exp_mem [256];
    // The line is pulled up; either party may only pull it low.
    assign sda = ~m_oe & ~(o_sda_oe & ~o_sda);
    ees_master um (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    ees_slave #(.WRITE_CYCLES(WCYC)) u_dut (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda),
        .i_addr_sel(addr_sel), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_busy(busy));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
        compares++;
        if (seen !== expv) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic final_report();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic page_wr(input logic [7:0] loc);
        logic [7:0] a;
        int n;
        a = loc;
        um.start();
        um.wbyte(own, nak);
        check("hdr ack", 8'(nak), 8'h00);
        um.wbyte(loc, nak);
        check("loc ack", 8'(nak), 8'h00);
        foreach (dq[i]) begin
            um.wbyte(dq[i], nak);
            check("data ack", 8'(nak), 8'h00);
            exp_mem[a] = dq[i];
            a = {a[7:3], a[2:0] + 3'h1};
        end
        um.stop();
        um.q(2);
        check("busy", 8'(busy), 8'h01);
        um.start();
        um.wbyte(own, nak);
        check("poll nak", 8'(nak), 8'h01);
        for (n = 0; nak && n < 20; n++) begin
            um.start();
            um.wbyte(own, nak);
        end
        check("poll ack", 8'(nak), 8'h00);
        um.stop();
        for (n = 0; n < 400 && busy; n++) um.q(1);
    endtask
    task automatic rd_chk(input logic [7:0] loc, input int n);
        um.start();
        um.wbyte(own, nak);
        um.wbyte(loc, nak);
        um.start();
        um.wbyte(own | 8'h01, nak);
        check("rd hdr", 8'(nak), 8'h00);
        for (int i = 0; i < n; i++) begin
            um.rbyte(i == n - 1, d);
            check("rd data", d, exp_mem[8'(loc + i)]);
        end
        um.stop();
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (o_sda_oe === 1'b1) begin
            check("drive level", 8'(o_sda), 8'h00);
        end
        if (cycles == 40000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        rst_b = 1'b0;
        addr_sel = 1'b0;
        own = `EES_FIXED_ADDR;
        void'($urandom(32'h19EE5D80));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        um.q(4);
        check("idle busy", 8'(busy), 8'h00);
        repeat (2) begin
            base = {5'($urandom_range(0, 18)), 3'h0};
            dq.delete();
            repeat (10) dq.push_back(8'($urandom));
            page_wr(base + 8'h03);
            rd_chk(base, 7);
            um.start();
            um.wbyte(own | 8'h01, nak);
            um.rbyte(1'b1, d);
            check("cur rd", d, exp_mem[base + 8'h07]);
            um.stop();
            dq.delete();
            dq.push_back(8'($urandom));
            page_wr(base + 8'($urandom_range(0, 7)));
            rd_chk(base, 8);
        end
        newa = {7'($urandom_range(1, 127)), 1'b0};
        um.start();
        um.wbyte(own ^ newa, nak);
        check("foreign hdr", 8'(nak), 8'h01);
        um.wbyte(8'h10, nak);
        check("foreign loc", 8'(nak), 8'h01);
        um.stop();
        um.q(4);
        check("foreign busy", 8'(busy), 8'h00);
        if (newa == `EES_FIXED_ADDR) newa = 8'h4C;
        dq.delete();
        dq.push_back(newa);
        page_wr(`EES_PROG_ADDR_LOC);
        addr_sel <= 1'b1;
        um.q(4);
        um.start();
        um.wbyte(`EES_FIXED_ADDR, nak);
        check("fixed off", 8'(nak), 8'h01);
        um.stop();
        own = newa;
        rd_chk(`EES_PROG_ADDR_LOC, 1);
        final_report();
    end
endmodule // ees_slave_bench

// *** core/ees_commit_timer.sv ***
`timescale 1ns/1ps
`include "ees_defs.svh"
// ==========================================
// Counts the nonvolatile write time after a page commit starts.
module ees_commit_timer #(
    parameter int unsigned WRITE_CYCLES = `EES_WRITE_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_start,
    output logic o_busy
);
    logic [31:0] cnt_q;
    initial begin
        if (WRITE_CYCLES < 1) $error("WRITE_CYCLES must be at least one");
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= 32'h0000_0000;
        end else if (i_start) begin
            cnt_q <= WRITE_CYCLES;
        end else if (cnt_q != 32'h0000_0000) begin
            cnt_q <= cnt_q - 32'h0000_0001;
        end
    end
    assign o_busy = (cnt_q != 32'h0000_0000);
endmodule // ees_commit_timer

// *** core/ees_slave.sv ***
`timescale 1ns/1ps
`include "ees_defs.svh"
// ==========================================
// Serial slave giving a bus master access to a 256-byte memory.
module ees_slave #(
    parameter int unsigned WRITE_CYCLES = `EES_WRITE_CYCLES,
    parameter int unsigned ROW_BYTES = `EES_ROW_BYTES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_addr_sel,
    output logic o_sda,
    output logic o_sda_oe,
    output logic o_busy
);
    initial begin
        if (ROW_BYTES != 8) $error("ROW_BYTES must be 8");
    end

    // ==========================================
    // Input sampling and bus condition detection.
    logic scl_s, sda_s, sel_s, scl_d1_q, sda_d1_q;
    ees_sync u_sync_scl (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_pin(i_scl), .o_sync(scl_s));
    ees_sync u_sync_sda (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_pin(i_sda), .o_sync(sda_s));
    ees_sync u_sync_sel (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_pin(i_addr_sel),
        .o_sync(sel_s));
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end else begin
            scl_d1_q <= scl_s;
            sda_d1_q <= sda_s;
        end
    end
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_s && !scl_d1_q;
    assign scl_fall = !scl_s && scl_d1_q;
    assign start_c = scl_s && scl_d1_q && sda_d1_q && !sda_s;
    assign stop_c = scl_s && scl_d1_q && !sda_d1_q && sda_s;

    // ==========================================
    // Memory, page buffer and commit timer.
    ees_pkg::ees_byte_t mem [0:255];
    ees_pkg::ees_byte_t page [0:7];
    logic [4:0] row_q;
    logic commit_q, busy;
    ees_commit_timer #(.WRITE_CYCLES(WRITE_CYCLES)) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_start(commit_q),
        .o_busy(busy)
    );

    function automatic logic [7:0] ees_next_in_row(input logic [7:0] a);
        ees_next_in_row = {a[7:3], a[2:0] + 3'h1};
    endfunction

    // ==========================================
    // Protocol state machine.
    ees_pkg::ees_state_e state_q;
    logic [7:0] shift_q, cnt_ptr_q, own_addr;
    logic [3:0] bit_q;
    logic rw_q, loc_next_q, wrote_q, ack_ok_q;
    assign own_addr = sel_s ? mem[`EES_PROG_ADDR_LOC] : `EES_FIXED_ADDR;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ees_pkg::EES_IDLE;
            shift_q <= 8'h00;
            bit_q <= 4'h0;
            rw_q <= 1'b0;
            loc_next_q <= 1'b0;
            wrote_q <= 1'b0;
            cnt_ptr_q <= 8'h00;
            commit_q <= 1'b0;
            ack_ok_q <= 1'b0;
            row_q <= 5'h00;
            o_sda <= 1'b0;
            o_sda_oe <= 1'b0;
        end else begin
            commit_q <= 1'b0;
            o_sda <= 1'b0;
            if (start_c) begin
                state_q <= ees_pkg::EES_ADDR;
                bit_q <= 4'h0;
                o_sda_oe <= 1'b0;
            end else if (stop_c) begin
                state_q <= ees_pkg::EES_IDLE;
                o_sda_oe <= 1'b0;
                if (wrote_q) begin
                    commit_q <= 1'b1;
                    wrote_q <= 1'b0;
                end
            end else begin
                case (state_q)
                    ees_pkg::EES_IDLE: begin
                    end
                    ees_pkg::EES_ADDR, ees_pkg::EES_WR: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_q <= bit_q + 4'h1;
                        end
                        if (scl_fall && bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            if (state_q == ees_pkg::EES_ADDR) begin
                                if (shift_q[7:1] == own_addr[7:1] && !busy) begin
                                    rw_q <= shift_q[0];
                                    loc_next_q <= !shift_q[0];
                                    o_sda_oe <= 1'b1;
                                    state_q <= ees_pkg::EES_ADDR_ACK;
                                end else begin
                                    state_q <= ees_pkg::EES_IDLE;
                                end
                            end else begin
                                if (loc_next_q) begin
                                    cnt_ptr_q <= shift_q;
                                    loc_next_q <= 1'b0;
                                end else begin
                                    if (!wrote_q || row_q != cnt_ptr_q[7:3]) begin
                                        row_q <= cnt_ptr_q[7:3];
                                    end
                                    page[cnt_ptr_q[2:0]] <= shift_q;
                                    wrote_q <= 1'b1;
                                    cnt_ptr_q <= ees_next_in_row(cnt_ptr_q);
                                end
                                o_sda_oe <= 1'b1;
                                state_q <= ees_pkg::EES_WR_ACK;
                            end
                        end
                    end
                    ees_pkg::EES_ADDR_ACK, ees_pkg::EES_WR_ACK: begin
                        if (scl_fall) begin
                            if (rw_q) begin
                                o_sda_oe <= !mem[cnt_ptr_q][7];
                                shift_q <= {mem[cnt_ptr_q][6:0], 1'b1};
                                bit_q <= 4'h1;
                                state_q <= ees_pkg::EES_RD;
                            end else begin
                                o_sda_oe <= 1'b0;
                                state_q <= ees_pkg::EES_WR;
                            end
                        end
                    end
                    ees_pkg::EES_RD: begin
                        if (scl_fall) begin
                            if (bit_q == 4'h8) begin
                                o_sda_oe <= 1'b0;
                                cnt_ptr_q <= cnt_ptr_q + 8'h01;
                                state_q <= ees_pkg::EES_RD_ACK;
                            end else begin
                                o_sda_oe <= !shift_q[7];
                                shift_q <= {shift_q[6:0], 1'b1};
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    end
                    ees_pkg::EES_RD_ACK: begin
                        if (scl_rise) begin
                            ack_ok_q <= !sda_s;
                        end
                        if (scl_fall) begin
                            if (ack_ok_q) begin
                                o_sda_oe <= !mem[cnt_ptr_q][7];
                                shift_q <= {mem[cnt_ptr_q][6:0], 1'b1};
                                bit_q <= 4'h1;
                                state_q <= ees_pkg::EES_RD;
                            end else begin
                                state_q <= ees_pkg::EES_IDLE;
                            end
                        end
                    end
                    default: state_q <= ees_pkg::EES_IDLE;
                endcase
            end
        end
    end

    // ==========================================
    // Page commit: only bytes written in the transfer are stored; untouched bytes of the row are not rewritten.
    logic [7:0] written_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            written_q <= 8'h00;
        end else if (start_c || commit_q) begin
            written_q <= 8'h00;
        end else if (state_q == ees_pkg::EES_WR && scl_fall && bit_q == 4'h8
                     && !loc_next_q) begin
            written_q[cnt_ptr_q[2:0]] <= 1'b1;
        end
    end
    // The array also carries its power-up contents, so this process is not an always_ff.
    always @(posedge i_ref_clk) begin
        if (commit_q) begin
            for (int i = 0; i < 8; i++) begin
                if (written_q[i]) begin
                    mem[{row_q, 3'(i)}] <= page[i];
                end
            end
        end
    end
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
        mem[`EES_PROG_ADDR_LOC] = `EES_PROG_ADDR_RST;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= busy || commit_q;
        end
    end

    // ==========================================
    // Checks.
    a_nack_busy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (state_q == ees_pkg::EES_ADDR && busy) |=> state_q != ees_pkg::EES_ADDR_ACK)
        else $error("address acknowledged while busy");
    a_sda_low_only: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        !o_sda) else $error("data line driven high");
    a_commit_busy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        commit_q |=> ##1 o_busy) else $error("no busy after commit");
    a_wrap_row: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (state_q == ees_pkg::EES_WR_ACK && $changed(cnt_ptr_q) && !rw_q && $past(!loc_next_q))
        |-> cnt_ptr_q[7:3] == $past(cnt_ptr_q[7:3])) else $error("row wrap broken");
    a_read_incr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        ($rose(state_q == ees_pkg::EES_RD_ACK)) |-> cnt_ptr_q == $past(cnt_ptr_q) + 8'h01)
        else $error("read counter not advanced");
    a_fixed_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        !sel_s |-> own_addr == `EES_FIXED_ADDR) else $error("wrong fixed address");
    a_stop_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        stop_c |=> state_q == ees_pkg::EES_IDLE && !o_sda_oe) else $error("stop ignored");
    a_rw_dir: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        $rose(state_q == ees_pkg::EES_ADDR_ACK) |-> rw_q == $past(shift_q[0]))
        else $error("direction bit wrong");
endmodule // ees_slave

// *** core/ees_sync.sv ***
`timescale 1ns/1ps
// ==========================================
// Two-stage synchroniser for pin inputs.
module ees_sync (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_pin,
    output logic o_sync
);
    logic meta_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= 1'b1;
            o_sync <= 1'b1;
        end else begin
            meta_q <= i_pin;
            o_sync <= meta_q;
        end
    end
endmodule // ees_sync

// *** shared/ees_defs.svh ***
`ifndef EES_DEFS_SVH
`define EES_DEFS_SVH
`define EES_FIXED_ADDR 8'hA2
`define EES_PROG_ADDR_LOC 8'h9F
`define EES_PROG_ADDR_RST 8'hA0
`define EES_ROW_BYTES 8
`define EES_WRITE_TIME_US 5000
`define EES_CLK_MHZ 100
`define EES_WRITE_CYCLES (`EES_WRITE_TIME_US * `EES_CLK_MHZ)
`endif

// *** shared/ees_pkg.sv ***
package ees_pkg;
    typedef enum logic [2:0] {
        EES_IDLE, EES_ADDR, EES_ADDR_ACK, EES_WR, EES_WR_ACK, EES_RD, EES_RD_ACK
    } ees_state_e;
    typedef logic [7:0] ees_byte_t;
endpackage
